/* inc/ddct_defs.svh */
// timing counts and reset values for the dual down counter timer
`ifndef DDCT_DEFS_SVH
`define DDCT_DEFS_SVH
`define DDCT_CNT_WIDTH 16
`define DDCT_POS_COUNT 16
`define DDCT_PRESCALE_DIV 4
`define DDCT_RESTART_RESET 16'h0000
`define DDCT_MAX_IN_KHZ_DIRECT 2500
`define DDCT_MAX_IN_KHZ_PRESCALED 10000
`endif

/* inc/ddct_pkg.sv */
// types shared by the dual down counter timer
package ddct_pkg;
	typedef logic [15:0] ddct_word_t;
	typedef logic [3:0] ddct_pos_t;
	typedef logic [15:0] ddct_irq_t;
endpackage

/* logic/ddct_half.sv */
// one 16-bit reloading down counter half
`timescale 1ns/1ps
`include "ddct_defs.svh"
module ddct_half
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic tick,
	input wire logic reloadNow,
	input ddct_pkg::ddct_word_t restartValue,
	output ddct_pkg::ddct_word_t count,
	output logic atZero
);
	import ddct_pkg::*;
	ddct_word_t next_count;
	assign atZero = (count == 16'h0000);
	// zero reloads the restart value instead of wrapping
	assign next_count = (reloadNow || atZero) ? restartValue // [R04]
		: count - 16'h0001; // [R01]
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			count <= `DDCT_RESTART_RESET;
		end else if (tick) begin
			count <= next_count;
		end
	end
	chk_reload_at_zero: assert property ( // [R04]
		@(posedge clk) disable iff (!reset_n)
		tick && atZero |=> count == $past(restartValue))
		else $error("half did not reload at zero");
	chk_down_step: assert property ( // [R01]
		@(posedge clk) disable iff (!reset_n)
		tick && !atZero && !reloadNow |=> count == $past(count) - 16'h0001)
		else $error("half did not step down");
endmodule

/* logic/dual_down_counter_timer.sv */
// dual 16-bit down counters with prescaler and 32-bit join
`timescale 1ns/1ps
`include "ddct_defs.svh"
// How it works
// [R01] two independent 16-bit counters, upper and lower, count down to zero
// [R02] each has a restart value register and a readable current count
// [R03] at zero a counter pulses the interrupt position software assigned it
// [R04] at zero the counter reloads its restart value and keeps counting
// [R05] optional divide-by-four prescaler on the counter input clock
// [R06] joined mode forms one 32-bit counter under upper control bits only
// [R07] joined: lower is low half, upper steps on lower underflow, both reload
module dual_down_counter_timer
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic counterClockIn,
	input wire logic prescaleEnable,
	input wire logic joinCounters,
	input wire logic upperRun,
	input wire logic lowerRun,
	input wire logic upperIrqEnable,
	input wire logic lowerIrqEnable,
	input ddct_pkg::ddct_pos_t upperIrqPos,
	input ddct_pkg::ddct_pos_t lowerIrqPos,
	input wire logic upperRestartWrite,
	input wire logic lowerRestartWrite,
	input ddct_pkg::ddct_word_t writeData,
	output ddct_pkg::ddct_word_t upper_restart_value,
	output ddct_pkg::ddct_word_t lower_restart_value,
	output ddct_pkg::ddct_word_t upper_current_count,
	output ddct_pkg::ddct_word_t lower_current_count,
	output ddct_pkg::ddct_irq_t interrupt_manager
);
	import ddct_pkg::*;
	logic lastClockIn;
	logic [1:0] prescaleCount;
	ddct_word_t upperCount;
	ddct_word_t lowerCount;
	logic upperZero;
	logic lowerZero;
	wire inEdge;
	wire countTick;
	wire upperTick;
	wire lowerTick;
	wire jointZero;
	wire upperFire;
	wire lowerFire;
	wire lowerEnabled;
	wire upperActive;
	ddct_irq_t next_irq;
	ddct_word_t lowerReloadValue;

	function automatic ddct_irq_t posDecode(input ddct_pos_t pos,
		input logic fire);
		posDecode = fire ? (16'h0001 << pos) : 16'h0000;
	endfunction

	// input is sampled; rising edges count, so it must stay below clk/2
	assign inEdge = counterClockIn && !lastClockIn;
	assign countTick = inEdge && (!prescaleEnable
		|| prescaleCount == 2'(`DDCT_PRESCALE_DIV - 1)); // [R05]
	assign upperActive = upperRun && countTick;
	// joined: lower's own run and interrupt bits are ignored
	assign lowerEnabled = joinCounters ? upperRun : lowerRun; // [R06]
	assign lowerTick = lowerEnabled && countTick;
	assign jointZero = upperZero && lowerZero;
	assign upperTick = joinCounters ? (lowerTick && lowerZero) // [R07]
		: upperActive;
	assign upperFire = upperIrqEnable && (joinCounters
		? (lowerTick && jointZero) : (upperActive && upperZero)); // [R06]
	assign lowerFire = !joinCounters && lowerIrqEnable && lowerTick
		&& lowerZero;
	assign next_irq = posDecode(upperIrqPos, upperFire)
		| posDecode(lowerIrqPos, lowerFire); // [R03]
	// joined: lower wraps to all ones until both halves sit at zero
	assign lowerReloadValue = (joinCounters && !jointZero) ? 16'hFFFF
		: lower_restart_value; // [R07]

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			lastClockIn <= 1'b0;
			prescaleCount <= 2'h0;
		end else begin
			lastClockIn <= counterClockIn;
			if (inEdge) begin
				prescaleCount <= prescaleCount + 2'h1; // [R05]
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			upper_restart_value <= `DDCT_RESTART_RESET;
			lower_restart_value <= `DDCT_RESTART_RESET;
		end else begin
			if (upperRestartWrite) begin
				upper_restart_value <= writeData; // [R02]
			end
			if (lowerRestartWrite) begin
				lower_restart_value <= writeData; // [R02]
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			upper_current_count <= 16'h0000;
			lower_current_count <= 16'h0000;
			interrupt_manager <= 16'h0000;
		end else begin
			upper_current_count <= upperCount; // [R02]
			lower_current_count <= lowerCount;
			interrupt_manager <= next_irq;
		end
	end

	// joined reload: at zero-zero the upper steps with lower and reloads
	ddct_half ddct_half_upper_inst (
		.clk(clk),
		.reset_n(reset_n),
		.tick(upperTick),
		.reloadNow(1'b0),
		.restartValue(upper_restart_value),
		.count(upperCount),
		.atZero(upperZero)
	);
	// joined: lower alone at zero must not reload until the pair is zero
	ddct_half ddct_half_lower_inst (
		.clk(clk),
		.reset_n(reset_n),
		.tick(lowerTick),
		.reloadNow(1'b0),
		.restartValue(lowerReloadValue), // [R07]
		.count(lowerCount),
		.atZero(lowerZero)
	);

	// interrupt strobes follow the tick at zero by one cycle
	chk_irq_on_zero: assert property ( // [R03]
		@(posedge clk) disable iff (!reset_n)
		upperActive && !joinCounters && upperZero && upperIrqEnable
		|=> interrupt_manager[$past(upperIrqPos)])
		else $error("upper zero gave no interrupt");
	chk_lower_irq: assert property ( // [R03]
		@(posedge clk) disable iff (!reset_n)
		lowerTick && !joinCounters && lowerZero && lowerIrqEnable
		|=> interrupt_manager[$past(lowerIrqPos)])
		else $error("lower zero gave no interrupt");
	chk_irq_pulse: assert property ( // [R03]
		@(posedge clk) disable iff (!reset_n)
		!countTick |=> interrupt_manager == 16'h0000)
		else $error("interrupt without a count tick");

	// pin edges reach the counters only through the prescaler gate
	chk_prescale_div: assert property ( // [R05]
		@(posedge clk) disable iff (!reset_n)
		prescaleEnable && countTick |-> prescaleCount == 2'h3)
		else $error("prescaled tick not every fourth edge");
	chk_direct_tick: assert property ( // [R05]
		@(posedge clk) disable iff (!reset_n)
		inEdge && !prescaleEnable && upperRun && !joinCounters && !upperZero
		|=> upperCount == $past(upperCount) - 16'h0001)
		else $error("direct input edge did not step the upper counter");

	// a stopped counter holds its value whatever the other one does; joined, lower stops on upperRun, not lowerRun
	chk_upper_hold: assert property ( // [R01]
		@(posedge clk) disable iff (!reset_n)
		!upperRun |=> upperCount == $past(upperCount))
		else $error("upper counted while stopped");
	chk_lower_hold: assert property ( // [R01]
		@(posedge clk) disable iff (!reset_n)
		!joinCounters && !lowerRun |=> lowerCount == $past(lowerCount))
		else $error("lower counted while stopped");

	// joined mode: lower run and interrupt bits must have no effect
	chk_join_lower: assert property ( // [R06]
		@(posedge clk) disable iff (!reset_n)
		joinCounters && !upperRun |=> lowerCount == $past(lowerCount))
		else $error("joined lower ran without upper run");
	chk_join_quiet: assert property ( // [R06]
		@(posedge clk) disable iff (!reset_n)
		joinCounters && upperIrqPos != lowerIrqPos
		|=> !interrupt_manager[$past(lowerIrqPos)])
		else $error("joined lower raised its own interrupt");
	chk_join_irq: assert property ( // [R06]
		@(posedge clk) disable iff (!reset_n)
		joinCounters && lowerTick && jointZero && upperIrqEnable
		|=> interrupt_manager[$past(upperIrqPos)])
		else $error("joined terminal count gave no interrupt");
	chk_join_carry: assert property ( // [R07]
		@(posedge clk) disable iff (!reset_n)
		joinCounters && lowerTick && !lowerZero
		|=> upperCount == $past(upperCount))
		else $error("upper stepped without lower underflow");
	chk_join_borrow: assert property ( // [R07]
		@(posedge clk) disable iff (!reset_n)
		joinCounters && lowerTick && lowerZero && !upperZero
		|=> lowerCount == 16'hFFFF
		&& upperCount == $past(upperCount) - 16'h0001)
		else $error("joined lower underflow did not borrow");
	chk_join_reload: assert property ( // [R07]
		@(posedge clk) disable iff (!reset_n)
		joinCounters && lowerTick && jointZero
		|=> upperCount == $past(upper_restart_value)
		&& lowerCount == $past(lower_restart_value))
		else $error("joined halves did not reload together");

	// the readable values lag the internal halves by one cycle
	chk_count_visible: assert property ( // [R02]
		@(posedge clk) disable iff (!reset_n)
		1'b1 |=> lower_current_count == $past(lowerCount))
		else $error("current count not shown");
	chk_upper_visible: assert property ( // [R02]
		@(posedge clk) disable iff (!reset_n)
		1'b1 |=> upper_current_count == $past(upperCount))
		else $error("upper current count not shown");
	chk_restart_store: assert property ( // [R02]
		@(posedge clk) disable iff (!reset_n)
		upperRestartWrite |=> upper_restart_value == $past(writeData))
		else $error("restart value not stored");
	chk_lower_store: assert property ( // [R02]
		@(posedge clk) disable iff (!reset_n)
		lowerRestartWrite |=> lower_restart_value == $past(writeData))
		else $error("lower restart value not stored");
	chk_restart_hold: assert property ( // [R02]
		@(posedge clk) disable iff (!reset_n)
		!upperRestartWrite |=> upper_restart_value == $past(upper_restart_value))
		else $error("restart value changed without a write");
endmodule

/* tb/ddct_clock_source.sv */
// counter clock source standing in for the far side
`timescale 1ns/1ps
module ddct_clock_source(
	input wire logic clk,
	output logic counterClockIn
);
	initial counterClockIn = 1'b0;
	// idles low between bursts; each phase spans several clk cycles
	task edges(input int n, input int half);
		repeat (n) begin
			@(negedge clk) counterClockIn = 1'b1;
			repeat (half) @(negedge clk);
			counterClockIn = 1'b0;
			repeat (half) @(negedge clk);
		end
	endtask
endmodule

/* tb/dual_down_counter_timer_test.sv */
// self-checking bench for the dual down counter timer
`timescale 1ns/1ps
module dual_down_counter_timer_test;
	import ddct_pkg::*;
	logic clk, reset_n, ctrIn, prescaleEnable, joinCounters;
	logic upperRun, lowerRun, upperIrqEnable, lowerIrqEnable;
	logic upperRestartWrite, lowerRestartWrite;
	ddct_pos_t upperIrqPos, lowerIrqPos;
	ddct_word_t writeData, upRst, loRst, upCnt, loCnt;
	ddct_irq_t irqLines;
	ddct_irq_t irqSeen = 16'h0000;
	int irqCnt, n_fail, checked, cycles;
	dual_down_counter_timer dual_down_counter_timer_inst(.clk(clk),
		.reset_n(reset_n), .counterClockIn(ctrIn),
		.prescaleEnable(prescaleEnable), .joinCounters(joinCounters),
		.upperRun(upperRun), .lowerRun(lowerRun),
		.upperIrqEnable(upperIrqEnable), .lowerIrqEnable(lowerIrqEnable),
		.upperIrqPos(upperIrqPos), .lowerIrqPos(lowerIrqPos),
		.upperRestartWrite(upperRestartWrite),
		.lowerRestartWrite(lowerRestartWrite), .writeData(writeData),
		.upper_restart_value(upRst), .lower_restart_value(loRst),
		.upper_current_count(upCnt), .lower_current_count(loCnt),
		.interrupt_manager(irqLines));
	ddct_clock_source ddct_clock_source_inst(.clk(clk), .counterClockIn(ctrIn));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// whole run is a few hundred cycles; the ceiling leaves ample margin
	always @(posedge clk) begin
		cycles++;
		if (irqLines !== 16'h0000) irqCnt++;
		irqSeen |= irqLines;
		if (cycles == 3000) begin
			n_fail++;
			give_verdict();
		end
	end
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task do_reset;
		reset_n = 1'b0;
		{prescaleEnable, joinCounters, upperRun, lowerRun} = 4'h0;
		{upperIrqEnable, lowerIrqEnable} = 2'h0;
		{upperRestartWrite, lowerRestartWrite} = 2'h0;
		{upperIrqPos, lowerIrqPos, writeData} = 24'h000000;
		repeat (8) @(negedge clk);
		reset_n = 1'b1;
		@(negedge clk);
	endtask
	task wr(input logic up, input ddct_word_t val);
		writeData = val;
		upperRestartWrite = up;
		lowerRestartWrite = ~up;
		@(negedge clk);
		upperRestartWrite = 1'b0;
		lowerRestartWrite = 1'b0;
		@(negedge clk);
	endtask
	task test_reload;
		do_reset();
		lowerIrqEnable = 1'b1;
		lowerIrqPos = 4'h5;
		lowerRun = 1'b1;
		wr(1'b0, 16'h0003);
		check(loRst, 16'h0003);
		irqSeen = 16'h0000;
		irqCnt = 0;
		ddct_clock_source_inst.edges(1, 3);
		check(loCnt, 16'h0003);
		check(irqSeen, 16'h0020);
		ddct_clock_source_inst.edges(3, 3);
		check({upCnt, loCnt}, 32'h00000000);
		ddct_clock_source_inst.edges(1, 3);
		check(loCnt, 16'h0003);
		check(irqCnt, 2);
	endtask
	task test_prescale;
		do_reset();
		prescaleEnable = 1'b1;
		upperRun = 1'b1;
		wr(1'b1, 16'h000A);
		check(upRst, 16'h000A);
		ddct_clock_source_inst.edges(4, 3);
		check(upCnt, 16'h000A);
		ddct_clock_source_inst.edges(4, 3);
		check(upCnt, 16'h0009);
	endtask
	task test_join;
		do_reset();
		{joinCounters, upperRun, upperIrqEnable, lowerIrqEnable} = 4'hF;
		upperIrqPos = 4'h9;
		lowerIrqPos = 4'h2;
		wr(1'b1, 16'h0001);
		wr(1'b0, 16'h0001);
		irqSeen = 16'h0000;
		ddct_clock_source_inst.edges(1, 3);
		check({upCnt, loCnt}, 32'h00010001);
		ddct_clock_source_inst.edges(2, 3);
		check({upCnt, loCnt}, 32'h0000FFFF);
		check(irqSeen, 16'h0200);
	endtask
	task test_split;
		do_reset();
		{upperRun, lowerRun, upperIrqEnable, lowerIrqEnable} = 4'hF;
		upperIrqPos = 4'hC;
		lowerIrqPos = 4'h3;
		wr(1'b1, 16'h0002);
		wr(1'b0, 16'h0004);
		irqSeen = 16'h0000;
		ddct_clock_source_inst.edges(1, 2);
		check({upCnt, loCnt}, 32'h00020004);
		check(irqSeen, 16'h1008);
		irqSeen = 16'h0000;
		ddct_clock_source_inst.edges(3, 2);
		check({upCnt, loCnt}, 32'h00020001);
		check(irqSeen, 16'h1000);
	endtask
	task test_join_wrap;
		do_reset();
		{joinCounters, lowerRun, upperIrqEnable} = 3'h7;
		upperIrqPos = 4'h6;
		wr(1'b1, 16'h0000);
		wr(1'b0, 16'h0002);
		ddct_clock_source_inst.edges(1, 2);
		check({upCnt, loCnt}, 32'h00000000);
		upperRun = 1'b1;
		ddct_clock_source_inst.edges(3, 2);
		check({upCnt, loCnt}, 32'h00000000);
		irqSeen = 16'h0000;
		ddct_clock_source_inst.edges(1, 2);
		check({upCnt, loCnt}, 32'h00000002);
		check(irqSeen, 16'h0040);
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		test_reload();
		test_prescale();
		test_join();
		test_split();
		test_join_wrap();
		give_verdict();
	end
endmodule
